// ===== dtp_pkg.sv
// Purpose: shared constants for the tone transceiver host port
// Assumes: ref_clk at 40 MHz, host strobes synchronous to ref_clk
// Notes: tone dividers are derived from the 40 MHz ref_clk (clk_hz)
package dtp_pkg;
  localparam logic sel_data = 1'b0;
  localparam logic sel_ctrl = 1'b1;
  // control_a fields
  localparam int ca_tone_out = 0;
  localparam int ca_cp_mode = 1;
  localparam int ca_irq_en = 2;
  localparam int ca_ptr = 3;
  // control_b fields
  localparam int cb_burst_off = 0;
  localparam int cb_test = 1;
  localparam int cb_single = 2;
  localparam int cb_column = 3;
  // status fields
  localparam int st_irq = 0;
  localparam int st_tx_empty = 1;
  localparam int st_rx_full = 2;
  localparam int st_absent = 3;
  localparam logic [3:0] ctrl_reset = 4'h0;
  localparam logic [3:0] code_reset = 4'h0;
  localparam logic [3:0] status_reset = 4'h8;
  // clocks
  localparam longint clk_hz = 40000000;
  localparam longint ref_hz = 3579545;
  localparam longint burst_ms = 51;
  localparam int burst_cycles = int'((clk_hz * burst_ms) / 1000);
  // one tone period is 64 segments; segment length in ref_clk cycles
  localparam int seg_w = 16;
  function automatic logic [seg_w-1:0] seg_len(input longint hz_x10);
    seg_len = seg_w'((clk_hz * 10) / (hz_x10 * 64));
  endfunction : seg_len
  localparam logic [seg_w-1:0] low_seg [4] = '{seg_len(6970), seg_len(7700),
    seg_len(8520), seg_len(9410)};
  localparam logic [seg_w-1:0] high_seg [4] = '{seg_len(12090), seg_len(13360),
    seg_len(14770), seg_len(16330)};
  typedef enum logic [1:0] {
    bst_idle = 2'b00,
    bst_tone = 2'b01,
    bst_pause = 2'b11
  } dtp_burst_type;
endpackage : dtp_pkg

// ===== dtp_tone_gen.sv
// Purpose: square-wave tone generator from a row and a column divider
// Assumes: segment lengths come from the package table
// Notes: half a tone period is 32 segments of ref_clk cycles
`timescale 1ns/1ps
module dtp_tone_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [3:0] code,
  input wire logic single,
  input wire logic column,
  output logic low_wave,
  output logic high_wave
);
  logic [1:0] row_idx;
  logic [1:0] col_idx;
  logic [dtp_pkg::seg_w-1:0] limit [2];
  logic [dtp_pkg::seg_w-1:0] cnt [2];
  logic [1:0] run;
  logic [1:0] wave;
  // code 0 stands for digit d; codes follow the keypad grid
  assign row_idx = code[1:0] == 2'b00 ? 2'(code[3:2] - 2'h1) : code[3:2];
  assign col_idx = 2'(code[1:0] - 2'h1);
  assign limit[0] = dtp_pkg::low_seg[row_idx];
  assign limit[1] = dtp_pkg::high_seg[col_idx];
  assign run[0] = enable && (!single || !column);
  assign run[1] = enable && (!single || column);
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt[g] <= '0;
          wave[g] <= 1'b0;
        end else if (!run[g]) begin
          cnt[g] <= '0;
          wave[g] <= 1'b0;
        end else if (cnt[g] >= limit[g] * 16'h20 - 16'h1) begin
          cnt[g] <= '0;
          wave[g] <= !wave[g];
        end else begin
          cnt[g] <= cnt[g] + 16'h1;
        end
      end
    end
  endgenerate
  assign low_wave = wave[0];
  assign high_wave = wave[1];
endmodule : dtp_tone_gen

// ===== dtp_host_port.sv
// What this block does
// - select and strobes pick register per access
// - receive code holds last valid digit
// - transmit code selects tone pair, write-only
// - pointer bit sends next control write to B
// - status read returns current transceiver state
// - every access completes in one cycle
// - shared pin is open drain, pulls low
// - control_a b0 gates all tone output
// - control_a b1 picks call progress mode
// - call progress square wave on shared pin
// - call progress mode blocks digit detection
// - tone mode interrupts on digit or ready
// - single tone mode from one group
// - eight tones within one percent
// - all timing from continuous reference clock
// - status bits, read clears b0 to b2
// - control_b b0 low gives timed bursts
// - control_b b2 single, b3 column select
// - test mode pin follows validated absence flag
// Purpose: host register port and control of a tone transceiver
// Assumes: strobes active low, one ref_clk per strobe cycle
// Notes: analog receive path enters as digit_valid, digit_code, cp_tone
`timescale 1ns/1ps
module dtp_host_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic register_select_line,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_oe_n,
  input wire logic digit_valid,
  input wire logic [3:0] digit_code,
  input wire logic cp_tone,
  output logic interrupt_or_tone_pin_out,
  output logic interrupt_or_tone_pin_oe_n,
  output logic low_tone,
  output logic high_tone
);
  logic [3:0] control_a;
  logic [3:0] control_b;
  logic control_b_pointer;
  logic [3:0] rx_code;
  logic [3:0] tx_code;
  logic [3:0] status;
  logic validated_absence_flag;
  logic digit_valid_d;
  dtp_pkg::dtp_burst_type bstate;
  dtp_pkg::dtp_burst_type next_bstate;
  logic [22:0] bcnt;
  logic [22:0] burst_len;
  logic tx_req;
  logic irq_req;
  logic low_wave;
  logic high_wave;
  logic pin_low;
  // access decode
  wire access = !cs_n && (rd_n != wr_n);
  wire wr_tx = access && !wr_n && register_select_line == dtp_pkg::sel_data;
  wire wr_ctrl = access && !wr_n && register_select_line == dtp_pkg::sel_ctrl;
  wire rd_rx = access && !rd_n && register_select_line == dtp_pkg::sel_data;
  wire rd_st = access && !rd_n && register_select_line == dtp_pkg::sel_ctrl;
  wire wr_a = wr_ctrl && !control_b_pointer;
  wire wr_b = wr_ctrl && control_b_pointer;
  wire cp_mode = control_a[dtp_pkg::ca_cp_mode];
  wire irq_en = control_a[dtp_pkg::ca_irq_en];
  wire burst_on = !control_b[dtp_pkg::cb_burst_off];
  wire new_digit = digit_valid && !digit_valid_d && !cp_mode;
  wire digit_gone = !digit_valid && digit_valid_d;
  wire burst_done = bstate == dtp_pkg::bst_pause && bcnt == 23'h0;
  wire tx_empty_set = burst_done && burst_on;
  wire tx_empty_clr = rd_st || !burst_on;
  wire [3:0] next_status;
  // set wins over a same-cycle read clear
  assign next_status[dtp_pkg::st_rx_full] = new_digit
    || (status[dtp_pkg::st_rx_full] && !rd_st);
  assign next_status[dtp_pkg::st_tx_empty] = tx_empty_set
    || (status[dtp_pkg::st_tx_empty] && !tx_empty_clr);
  assign next_status[dtp_pkg::st_irq] = new_digit || tx_empty_set
    || (status[dtp_pkg::st_irq] && !rd_st);
  assign next_status[dtp_pkg::st_absent] = validated_absence_flag;
  assign burst_len = cp_mode ? 23'(2 * dtp_pkg::burst_cycles)
    : 23'(dtp_pkg::burst_cycles);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_a <= dtp_pkg::ctrl_reset;
      control_b <= dtp_pkg::ctrl_reset;
      control_b_pointer <= 1'b0;
    end else if (wr_a) begin
      control_a <= data_in;
      control_b_pointer <= data_in[dtp_pkg::ca_ptr];
    end else if (wr_b) begin
      control_b <= data_in;
      control_b_pointer <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_code <= dtp_pkg::code_reset;
      digit_valid_d <= 1'b0;
      validated_absence_flag <= 1'b1;
      status <= dtp_pkg::status_reset;
    end else begin
      digit_valid_d <= digit_valid;
      if (new_digit) begin
        rx_code <= digit_code;
      end
      if (new_digit) begin
        validated_absence_flag <= 1'b0;
      end else if (digit_gone) begin
        validated_absence_flag <= 1'b1;
      end
      status <= next_status;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_code <= dtp_pkg::code_reset;
      tx_req <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_code <= data_in;
      end
      tx_req <= wr_tx && burst_on;
    end
  end
  // burst timer
  always_comb begin
    next_bstate = bstate;
    case (bstate)
      dtp_pkg::bst_idle: begin
        if (tx_req) begin
          next_bstate = dtp_pkg::bst_tone;
        end
      end
      dtp_pkg::bst_tone: begin
        if (!burst_on) begin
          next_bstate = dtp_pkg::bst_idle;
        end else if (bcnt == 23'h0) begin
          next_bstate = dtp_pkg::bst_pause;
        end
      end
      dtp_pkg::bst_pause: begin
        if (!burst_on || bcnt == 23'h0) begin
          next_bstate = dtp_pkg::bst_idle;
        end
      end
      default: begin
        next_bstate = dtp_pkg::bst_idle;
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bstate <= dtp_pkg::bst_idle;
      bcnt <= '0;
    end else begin
      bstate <= next_bstate;
      if (next_bstate != bstate) begin
        bcnt <= 23'(burst_len - 23'h1);
      end else if (bcnt != 23'h0) begin
        bcnt <= bcnt - 23'h1;
      end
    end
  end
  wire tone_gate = control_a[dtp_pkg::ca_tone_out]
    && (!burst_on || bstate == dtp_pkg::bst_tone);
  dtp_tone_gen i_dtp_tone_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(tone_gate),
    .code(tx_code),
    .single(control_b[dtp_pkg::cb_single]),
    .column(control_b[dtp_pkg::cb_column]),
    .low_wave(low_wave),
    .high_wave(high_wave)
  );
  // shared pin: low means interrupt, low half of call progress wave, or digit present in test mode
  assign irq_req = status[dtp_pkg::st_rx_full] || status[dtp_pkg::st_tx_empty];
  always_comb begin
    pin_low = 1'b0;
    if (cp_mode) begin
      pin_low = irq_en && !cp_tone;
    end else if (control_b[dtp_pkg::cb_test]) begin
      pin_low = !validated_absence_flag;
    end else begin
      pin_low = irq_en && irq_req;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= 4'h0;
      data_oe_n <= 1'b1;
      interrupt_or_tone_pin_out <= 1'b0;
      interrupt_or_tone_pin_oe_n <= 1'b1;
      low_tone <= 1'b0;
      high_tone <= 1'b0;
    end else begin
      data_oe_n <= !(rd_rx || rd_st);
      data_out <= rd_st ? status : rx_code;
      interrupt_or_tone_pin_out <= 1'b0;
      interrupt_or_tone_pin_oe_n <= !pin_low;
      low_tone <= low_wave;
      high_tone <= high_wave;
    end
  end
  property p_ptr_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_b |=> !control_b_pointer;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer kept after B write");
  property p_ptr_set;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_a && data_in[dtp_pkg::ca_ptr] |=> control_b_pointer;
  endproperty
  a_ptr_set: assert property (p_ptr_set) else $error("pointer not set");
  property p_wr_a;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_a |=> control_a == $past(data_in);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("control_a not written");
  property p_wr_b;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_b |=> control_b == $past(data_in);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("control_b not written");
  property p_ctrl_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !wr_ctrl |=> $stable(control_a) && $stable(control_b) && $stable(control_b_pointer);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");
  property p_read_status;
    @(posedge ref_clk) disable iff (sys_rst)
      rd_st |=> !data_oe_n && data_out == $past(status);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");
  property p_oe_idle;
    @(posedge ref_clk) disable iff (sys_rst)
      !rd_rx && !rd_st |=> data_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data driven without read");
  property p_rx_set;
    @(posedge ref_clk) disable iff (sys_rst)
      new_digit |=> status[dtp_pkg::st_rx_full] && status[dtp_pkg::st_irq];
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive flags not set");
  property p_absent_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      new_digit |-> ##2 !status[dtp_pkg::st_absent];
  endproperty
  a_absent_clear: assert property (p_absent_clear) else $error("absence bit kept");
  property p_absent_set;
    @(posedge ref_clk) disable iff (sys_rst)
      digit_gone |-> ##2 status[dtp_pkg::st_absent];
  endproperty
  a_absent_set: assert property (p_absent_set) else $error("absence bit not set");
  property p_cp_pin;
    @(posedge ref_clk) disable iff (sys_rst)
      cp_mode && irq_en |=> interrupt_or_tone_pin_oe_n == $past(cp_tone);
  endproperty
  a_cp_pin: assert property (p_cp_pin) else $error("call progress wave wrong");
  property p_test_pin;
    @(posedge ref_clk) disable iff (sys_rst)
      !cp_mode && control_b[dtp_pkg::cb_test]
        |=> interrupt_or_tone_pin_oe_n == $past(validated_absence_flag);
  endproperty
  a_test_pin: assert property (p_test_pin) else $error("test pin wrong");
  property p_irq_read;
    @(posedge ref_clk) disable iff (sys_rst)
      rd_st && !new_digit && !tx_empty_set |=> !status[dtp_pkg::st_irq];
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("irq bit not cleared");
  property p_nonburst;
    @(posedge ref_clk) disable iff (sys_rst)
      !burst_on |=> !status[dtp_pkg::st_tx_empty];
  endproperty
  a_nonburst: assert property (p_nonburst) else $error("tx empty outside burst");
  property p_burst_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      burst_on && bstate != dtp_pkg::bst_tone |=> !low_wave && !high_wave;
  endproperty
  a_burst_gate: assert property (p_burst_gate) else $error("tone outside burst");
  property p_burst_start;
    @(posedge ref_clk) disable iff (sys_rst)
      bstate == dtp_pkg::bst_idle && tx_req |=> bstate == dtp_pkg::bst_tone;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst not started");
  property p_rx_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !new_digit |=> $stable(rx_code);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx code changed");
  property p_tx_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !wr_tx |=> $stable(tx_code);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx code changed");
  property p_row_only;
    @(posedge ref_clk) disable iff (sys_rst)
      control_b[dtp_pkg::cb_single] && !control_b[dtp_pkg::cb_column] |=> !high_wave;
  endproperty
  a_row_only: assert property (p_row_only) else $error("column tone in row mode");
  property p_rx_latch;
    @(posedge ref_clk) disable iff (sys_rst) new_digit |=> rx_code == $past(digit_code);
  endproperty
  a_rx_latch: assert property (p_rx_latch) else $error("rx code not latched");
  property p_cp_block;
    @(posedge ref_clk) disable iff (sys_rst)
      cp_mode && !rd_st |=> status[2] == $past(status[2]);
  endproperty
  a_cp_block: assert property (p_cp_block) else $error("digit flag moved in cp mode");
  property p_read_clear;
    @(posedge ref_clk) disable iff (sys_rst) rd_st && !new_digit |=> !status[2];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");
  property p_read_data;
    @(posedge ref_clk) disable iff (sys_rst)
      rd_rx |=> !data_oe_n && data_out == $past(rx_code);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");
  property p_tx_write;
    @(posedge ref_clk) disable iff (sys_rst) wr_tx |=> tx_code == $past(data_in);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx code not written");
  property p_tone_off;
    @(posedge ref_clk) disable iff (sys_rst)
      !control_a[0] [*2] |=> !low_wave && !high_wave;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("tone out while disabled");
  property p_irq_pin;
    @(posedge ref_clk) disable iff (sys_rst)
      !cp_mode && !control_b[1] && irq_en && irq_req |=> !interrupt_or_tone_pin_oe_n;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt not driven");
  property p_pin_release;
    @(posedge ref_clk) disable iff (sys_rst)
      !cp_mode && !control_b[1] && !irq_req |=> interrupt_or_tone_pin_oe_n;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released");
  c_ctrl_b: cover property (@(posedge ref_clk) disable iff (sys_rst) wr_b);
  c_digit: cover property (@(posedge ref_clk) disable iff (sys_rst) new_digit);
  c_burst: cover property (@(posedge ref_clk) disable iff (sys_rst) tx_empty_set);
  c_cp_wave: cover property (@(posedge ref_clk) disable iff (sys_rst) cp_mode && !cp_tone);
  c_test_pin: cover property (@(posedge ref_clk) disable iff (sys_rst)
    !cp_mode && control_b[dtp_pkg::cb_test] && !validated_absence_flag);
endmodule : dtp_host_port

// ===== dtp_host_model.sv
// Purpose: host microcontroller model on the strobed parallel bus
// Assumes: one ref_clk per bus cycle, signals move just after a rising edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module dtp_host_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic register_select_line,
  output logic wr_n,
  output logic rd_n,
  output logic [3:0] data_in,
  input wire logic [3:0] data_out
);
  logic ale = 1'b0;
  logic hi_dec = 1'b0;
  assign cs_n = ~(ale & hi_dec);
  initial begin
    register_select_line = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 4'h0;
  end
  // one strobe cycle, no wait states
  task automatic cyc(input logic sel, input logic wr, input logic [3:0] d,
      output logic [3:0] q);
    @(posedge ref_clk);
    ale <= 1'b1;
    hi_dec <= 1'b1;
    register_select_line <= sel;
    wr_n <= ~wr;
    rd_n <= wr;
    data_in <= d;
    @(posedge ref_clk);
    ale <= 1'b0;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    data_in <= ~d;
    #1;
    q = data_out;
  endtask : cyc
  task automatic wr(input logic sel, input logic [3:0] d);
    logic [3:0] q;
    cyc(sel, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic sel, output logic [3:0] q);
    cyc(sel, 1'b0, 4'h0, q);
  endtask : rd
  // software reset of both control registers
  task automatic init();
    logic [3:0] q;
    rd(1'b1, q);
    wr(1'b1, 4'h0);
    wr(1'b1, 4'h0);
    wr(1'b1, 4'h8);
    wr(1'b1, 4'h0);
    rd(1'b1, q);
  endtask : init
endmodule : dtp_host_model

// ===== dtp_host_port_test.sv
// Purpose: self-checking bench for the tone transceiver host port
// Assumes: host model drives the bus, bench drives the receive side
// Notes: burst length is not timed, its count is too long
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dtp_host_port_test;
  logic ref_clk, sys_rst, cs_n, rsl, wr_n, rd_n, data_oe_n, digit_valid, cp_tone;
  logic [3:0] data_in, data_out, digit_code, q;
  logic pin_out, pin_oe_n, low_tone, high_tone, pin;
  int mismatches = 0;
  int cmp_count = 0;
  assign pin = pin_oe_n ? 1'b1 : pin_out;
  dtp_host_model i_dtp_host_model (.ref_clk(ref_clk), .cs_n(cs_n),
    .register_select_line(rsl), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
    .data_out(data_out));
  dtp_host_port i_dtp_host_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .register_select_line(rsl), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .digit_valid(digit_valid),
    .digit_code(digit_code), .cp_tone(cp_tone), .interrupt_or_tone_pin_out(pin_out),
    .interrupt_or_tone_pin_oe_n(pin_oe_n), .low_tone(low_tone), .high_tone(high_tone));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic t_reset_and_pointer();
    i_dtp_host_model.rd(1'b1, q);
    `CHK(q, 4'h8)
    i_dtp_host_model.init();
    i_dtp_host_model.wr(1'b1, 4'h8);
    i_dtp_host_model.wr(1'b1, 4'h1);
    i_dtp_host_model.wr(1'b1, 4'h4);
  endtask : t_reset_and_pointer
  task automatic t_digit();
    @(posedge ref_clk);
    digit_code <= 4'h5;
    digit_valid <= 1'b1;
    settle(3);
    `CHK(pin, 1'b0)
    i_dtp_host_model.rd(1'b0, q);
    `CHK(q, 4'h5)
    `CHK(data_oe_n, 1'b0)
    i_dtp_host_model.rd(1'b1, q);
    `CHK(q, 4'h5)
    settle(2);
    `CHK(pin, 1'b1)
    `CHK(data_oe_n, 1'b1)
    i_dtp_host_model.rd(1'b1, q);
    `CHK(q, 4'h0)
    @(posedge ref_clk);
    digit_valid <= 1'b0;
    settle(3);
  endtask : t_digit
  task automatic t_call_progress();
    i_dtp_host_model.wr(1'b1, 4'h6);
    @(posedge ref_clk);
    digit_code <= 4'h9;
    digit_valid <= 1'b1;
    settle(3);
    i_dtp_host_model.rd(1'b0, q);
    `CHK(q, 4'h5)
    i_dtp_host_model.rd(1'b1, q);
    `CHK(q[2], 1'b0)
    @(posedge ref_clk);
    cp_tone <= 1'b0;
    settle(3);
    `CHK(pin, 1'b0)
    @(posedge ref_clk);
    cp_tone <= 1'b1;
    settle(3);
    `CHK(pin, 1'b1)
    @(posedge ref_clk);
    digit_valid <= 1'b0;
    settle(3);
  endtask : t_call_progress
  task automatic t_tone_gate();
    logic h0;
    int n;
    i_dtp_host_model.wr(1'b1, 4'h5);
    i_dtp_host_model.wr(1'b0, 4'h7);
    settle(2);
    h0 = high_tone;
    n = 0;
    while (high_tone === h0 && n < 30000) begin
      settle(1);
      n++;
    end
    `CHK(high_tone, ~h0)
    // half period of 1477 Hz at 40 MHz, within one percent
    h0 = high_tone;
    n = 0;
    while (high_tone === h0 && n < 30000) begin
      settle(1);
      n++;
    end
    `CHK(n > 13405 && n < 13676, 1'b1)
    i_dtp_host_model.wr(1'b1, 4'h4);
    settle(4);
    for (n = 0; n < 2000; n++) begin
      if (n % 500 == 0) `CHK({low_tone, high_tone}, 2'b00)
      settle(1);
    end
  endtask : t_tone_gate
  task automatic t_single_tone();
    logic h0;
    logic hi_seen;
    int n;
    i_dtp_host_model.wr(1'b1, 4'h9);
    i_dtp_host_model.wr(1'b1, 4'h5);
    settle(2);
    h0 = low_tone;
    hi_seen = 1'b0;
    n = 0;
    while (low_tone === h0 && n < 30000) begin
      hi_seen = hi_seen | high_tone;
      settle(1);
      n++;
    end
    `CHK(low_tone, ~h0)
    `CHK(hi_seen, 1'b0)
  endtask : t_single_tone
  task automatic t_test_mode();
    i_dtp_host_model.wr(1'b1, 4'h8);
    i_dtp_host_model.wr(1'b1, 4'h3);
    @(posedge ref_clk);
    digit_code <= 4'h2;
    digit_valid <= 1'b1;
    settle(4);
    `CHK(pin, 1'b0)
    @(posedge ref_clk);
    digit_valid <= 1'b0;
    settle(4);
    `CHK(pin, 1'b1)
    i_dtp_host_model.rd(1'b0, q);
    `CHK(q, 4'h2)
    i_dtp_host_model.rd(1'b1, q);
    `CHK(q, 4'hd)
  endtask : t_test_mode
  task automatic t_burst();
    logic seen;
    int n;
    i_dtp_host_model.wr(1'b1, 4'h9);
    i_dtp_host_model.wr(1'b1, 4'h0);
    seen = 1'b0;
    for (n = 0; n < 12500; n++) begin
      seen = seen | low_tone | high_tone;
      settle(1);
    end
    `CHK(seen, 1'b0)
    i_dtp_host_model.wr(1'b0, 4'h4);
    n = 0;
    while (high_tone === 1'b0 && n < 14000) begin
      settle(1);
      n++;
    end
    `CHK(high_tone, 1'b1)
  endtask : t_burst
  initial begin
    sys_rst = 1'b1;
    digit_valid = 1'b0;
    digit_code = 4'h0;
    cp_tone = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_and_pointer();
    t_digit();
    t_call_progress();
    t_tone_gate();
    t_single_tone();
    t_test_mode();
    t_burst();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
endmodule : dtp_host_port_test
